// [banked_ram.v]
// Small register memory for the banked and shared general registers.
`timescale 1ns/1ps
module banked_ram (
  input  wire        i_clk,
  input  wire        i_we,
  input  wire [4:0]  i_waddr,
  input  wire [31:0] i_wdata,
  input  wire [4:0]  i_raddr,
  output reg  [31:0] o_rdata
);
  reg [31:0] mem [0:31];

  // Read data come from a register, so a read is seen one cycle after its address.
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// [psr_defines.vh]
// Status register field positions, mode codes, bank indices and reset values.
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH
`define PSR_N         31
`define PSR_Z         30
`define PSR_C         29
`define PSR_V         28
`define PSR_Q         27
`define PSR_J         24
`define PSR_I         7
`define PSR_F         6
`define PSR_T         5
`define PSR_MODE_HI   4
`define PSR_FLAG_MASK 32'hF8000000
`define PSR_CTRL_MASK 32'h000000FF
`define PSR_RSVD_MASK 32'h06FFFF00
`define MODE_USR      5'h10
`define MODE_FIQ      5'h11
`define MODE_IRQ      5'h12
`define MODE_SVC      5'h13
`define MODE_ABT      5'h17
`define MODE_UND      5'h1B
`define MODE_SYS      5'h1F
`define PSR_RESET     32'h000000D3
`define SAVED_STATUS_FIQ      3'h0
`define SAVED_STATUS_IRQ      3'h1
`define SAVED_STATUS_SVC      3'h2
`define SAVED_STATUS_ABT      3'h3
`define SAVED_STATUS_UNDEF_MODE      3'h4
`define SAVED_STATUS_NONE     3'h7
`define BANK_WORDS    6'h20
`endif

// [status_regs_and_banking.v]
// Status registers, mode decode and mode-banked general register view.
//
// Behaviour
// - Decode seven mode codes, select register bank.
// - Illegal mode code locks up until reset.
// - Compact state: only low regs, SP, LR, PC; here r13-r15 also need special ops.
// - Per exception mode stack pointer, link, saved status; user and system share r13/r14 and have none.
// - Compact high-register access only via special ops.
// - One current, five saved status registers.
// - Unused status bits read and write back; in user mode writes reach only the flag bits.
// - Flags update from ALU, status writes, loads.
// - Native all conditional; compact only branches.
// - Sticky saturation set by saturating ops.
// - No condition tests the saturation flag.
// - Bytecode bit, else compact bit, selects state.
// - Both state bits set: undefined on next instruction.
// - Status writes never change the bytecode bit.
// - Low eight control bits, privileged write only.
// - Mask bits block normal and fast interrupts.
// - Compact bit reflects compact execution state.
// - State bits driven on two output pins.
// - Fast mode banks r8 to r14.
// - Reset: supervisor, masks set, state bits clear.
// - Exception entry saves current into saved status.
`timescale 1ns/1ps
`include "psr_defines.vh"
module status_regs_and_banking (
  input  wire        I_CLK,
  input  wire        I_RST,
  input  wire        i_flag_we,
  input  wire [3:0]  i_flag_nzcv,
  input  wire        i_sat_set,
  input  wire        i_status_we,
  input  wire        i_status_to_saved,
  input  wire [31:0] i_status_wdata,
  input  wire [3:0]  i_status_fmask,
  input  wire        i_exc_enter,
  input  wire [4:0]  i_exc_mode,
  input  wire        i_exc_mask_fiq,
  input  wire        i_exc_return,
  input  wire        i_state_we,
  input  wire        i_state_compact,
  input  wire        i_state_bytecode,
  input  wire        i_high_access,
  input  wire [3:0]  i_cond,
  input  wire        i_is_branch,
  input  wire        i_irq_req,
  input  wire        i_fiq_req,
  input  wire        i_gpr_we,
  input  wire [3:0]  i_gpr_waddr,
  input  wire [31:0] i_gpr_wdata,
  input  wire [3:0]  i_gpr_raddr,
  output reg  [31:0] O_CURRENT_STATUS,
  output reg  [31:0] O_SAVED_STATUS,
  output reg         O_COMPACT_STATE_OUT,
  output reg         O_BYTECODE_STATE_OUT,
  output reg         O_COND_PASS,
  output reg         O_UNDEF_TRAP,
  output reg         O_IRQ_TAKE,
  output reg         O_FIQ_TAKE,
  output reg         O_LOCKED,
  output reg         O_ACCESS_ERR,
  output wire [31:0] O_GPR_RDATA
);
  reg  [31:0] current_status;
  reg  [31:0] saved_status [0:4];
  reg         locked;
  reg  [31:0] next_status;
  reg  [31:0] wmask;
  integer     k;

  wire [4:0] mode = current_status[`PSR_MODE_HI:0];
  wire       compact = current_status[`PSR_T] & ~current_status[`PSR_J];

  // Saved status slot of a mode, or none for user and system.
  function [2:0] saved_index;
    input [4:0] m;
    begin
      if (m == `MODE_FIQ) saved_index = `SAVED_STATUS_FIQ;
      else if (m == `MODE_IRQ) saved_index = `SAVED_STATUS_IRQ;
      else if (m == `MODE_SVC) saved_index = `SAVED_STATUS_SVC;
      else if (m == `MODE_ABT) saved_index = `SAVED_STATUS_ABT;
      else if (m == `MODE_UND) saved_index = `SAVED_STATUS_UNDEF_MODE;
      else saved_index = `SAVED_STATUS_NONE;
    end
  endfunction

  function mode_legal;
    input [4:0] m;
    begin
      mode_legal = (m == `MODE_USR) || (m == `MODE_SYS) ||
                   (saved_index(m) != `SAVED_STATUS_NONE);
    end
  endfunction

  // Physical slot of a visible register: 0-15 shared, 16-22 fast r8-r14,
  // then r13/r14 pairs for irq, svc, abt, und.
  function [4:0] phys;
    input [4:0] m;
    input [3:0] r;
    reg   [2:0] s;
    begin
      s = saved_index(m);
      if (s == `SAVED_STATUS_FIQ && r >= 4'h8 && r <= 4'hE) phys = {1'b1, r} - 5'h08;
      else if (s != `SAVED_STATUS_NONE && r >= 4'hD && r <= 4'hE)
        phys = 5'h17 + {s[1:0] - 2'h1, 1'b0} + {4'h0, r[0] ^ 1'b1};
      else phys = {1'b0, r};
    end
  endfunction

  // Condition evaluation uses only N, Z, C, V; the saturation bit is never looked at.
  function cond_ok;
    input [3:0]  c;
    input [31:0] p;
    reg n, z, cf, v;
    begin
      n = p[`PSR_N]; z = p[`PSR_Z]; cf = p[`PSR_C]; v = p[`PSR_V];
      case (c[3:1])
        3'h0: cond_ok = z;
        3'h1: cond_ok = cf;
        3'h2: cond_ok = n;
        3'h3: cond_ok = v;
        3'h4: cond_ok = cf & ~z;
        3'h5: cond_ok = (n == v);
        3'h6: cond_ok = ~z & (n == v);
        default: cond_ok = 1'b1;
      endcase
      if (c[3:1] != 3'h7) cond_ok = cond_ok ^ c[0];
    end
  endfunction

  wire [2:0] cur_slot = saved_index(mode);
  wire [2:0] exc_slot = saved_index(i_exc_mode);
  wire       priv = (mode != `MODE_USR);
  // In compact state r8-r15 are reachable only through the special move/compare/add forms.
  wire       high_reg = i_gpr_waddr[3] | i_gpr_raddr[3];
  wire       gpr_block = compact & high_reg & ~i_high_access;

  always @* begin
    next_status = current_status;
    wmask = 32'h00000000;
    if (i_flag_we) begin
      next_status[`PSR_N:`PSR_V] = i_flag_nzcv;
    end
    if (i_status_we && !i_status_to_saved) begin
      if (i_status_fmask[3]) wmask = wmask | 32'hFF000000;
      if (i_status_fmask[2]) wmask = wmask | 32'h00FF0000;
      if (i_status_fmask[1]) wmask = wmask | 32'h0000FF00;
      if (i_status_fmask[0] && priv) wmask = wmask | `PSR_CTRL_MASK;
      if (!priv) wmask = wmask & `PSR_FLAG_MASK;
      wmask[`PSR_J] = 1'b0;
      // The compact bit is written as software asks; forcing it is left undefined.
      next_status = (next_status & ~wmask) | (i_status_wdata & wmask);
    end
    if (i_sat_set) next_status[`PSR_Q] = 1'b1;
    if (i_state_we) begin
      next_status[`PSR_T] = i_state_compact;
      next_status[`PSR_J] = i_state_bytecode;
    end
    if (i_exc_return && cur_slot != `SAVED_STATUS_NONE) begin
      next_status = saved_status[cur_slot];
    end
    if (i_exc_enter && exc_slot != `SAVED_STATUS_NONE) begin
      next_status[`PSR_MODE_HI:0] = i_exc_mode;
      next_status[`PSR_I] = 1'b1;
      if (i_exc_mask_fiq) next_status[`PSR_F] = 1'b1;
      next_status[`PSR_T] = 1'b0;
      next_status[`PSR_J] = 1'b0;
    end
  end

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      current_status <= `PSR_RESET;
      locked <= 1'b0;
      for (k = 0; k < 5; k = k + 1) begin
        saved_status[k] <= 32'h00000000;
      end
    end else begin
      // Once the mode field is illegal nothing moves until reset.
      if (!locked) begin
        current_status <= next_status;
        locked <= ~mode_legal(next_status[`PSR_MODE_HI:0]);
        if (i_exc_enter && exc_slot != `SAVED_STATUS_NONE) begin
          saved_status[exc_slot] <= current_status;
        end else if (i_status_we && i_status_to_saved && cur_slot != `SAVED_STATUS_NONE) begin
          saved_status[cur_slot] <= i_status_wdata;
        end
      end
    end
  end

  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CURRENT_STATUS <= `PSR_RESET;
      O_SAVED_STATUS <= 32'h00000000;
      O_COMPACT_STATE_OUT <= 1'b0;
      O_BYTECODE_STATE_OUT <= 1'b0;
      O_COND_PASS <= 1'b0;
      O_UNDEF_TRAP <= 1'b0;
      O_IRQ_TAKE <= 1'b0;
      O_FIQ_TAKE <= 1'b0;
      O_LOCKED <= 1'b0;
      O_ACCESS_ERR <= 1'b0;
    end else begin
      O_CURRENT_STATUS <= current_status;
      O_SAVED_STATUS <= (cur_slot == `SAVED_STATUS_NONE) ? 32'h00000000 : saved_status[cur_slot];
      O_COMPACT_STATE_OUT <= current_status[`PSR_T];
      O_BYTECODE_STATE_OUT <= current_status[`PSR_J];
      if (compact && !i_is_branch) O_COND_PASS <= 1'b1;
      else O_COND_PASS <= cond_ok(i_cond, current_status);
      O_UNDEF_TRAP <= current_status[`PSR_J] & current_status[`PSR_T];
      O_IRQ_TAKE <= i_irq_req & ~current_status[`PSR_I] & ~locked;
      O_FIQ_TAKE <= i_fiq_req & ~current_status[`PSR_F] & ~locked;
      O_LOCKED <= locked;
      O_ACCESS_ERR <= gpr_block;
    end
  end

  banked_ram u_ram (
    .i_clk   (I_CLK),
    .i_we    (i_gpr_we & ~gpr_block & ~locked),
    .i_waddr (phys(mode, i_gpr_waddr)),
    .i_wdata (i_gpr_wdata),
    .i_raddr (phys(mode, i_gpr_raddr)),
    .o_rdata (O_GPR_RDATA)
  );
endmodule

// [status_regs_and_banking_bench.sv]
// Directed bench for the status register block.
`timescale 1ns/1ps
module status_regs_and_banking_bench;
  reg I_CLK = 1'b0;
  reg I_RST = 1'b1;
  reg i_flag_we, i_sat_set, i_status_we, i_status_to_saved, i_exc_enter, i_exc_mask_fiq;
  reg i_exc_return, i_state_we, i_state_compact, i_state_bytecode, i_high_access;
  reg i_is_branch, i_irq_req, i_fiq_req, i_gpr_we;
  reg [3:0] i_flag_nzcv, i_status_fmask, i_cond, i_gpr_waddr, i_gpr_raddr;
  reg [4:0] i_exc_mode;
  reg [31:0] i_status_wdata, i_gpr_wdata;
  wire [31:0] O_CURRENT_STATUS, O_SAVED_STATUS, O_GPR_RDATA;
  wire O_COMPACT_STATE_OUT, O_BYTECODE_STATE_OUT, O_COND_PASS, O_UNDEF_TRAP;
  wire O_IRQ_TAKE, O_FIQ_TAKE, O_LOCKED, O_ACCESS_ERR;
  integer miscompares = 0, n_checks = 0, cycles = 0;
  status_regs_and_banking dut (.*);
  always #5 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Pulses last one edge; outputs are read two edges after the request.
  task tick;
    begin
      @(posedge I_CLK);
      {i_flag_we, i_sat_set, i_status_we, i_exc_enter, i_exc_return, i_state_we} <= 6'h00;
      i_gpr_we <= 1'b0;
      @(posedge I_CLK);
      #1;
    end
  endtask
  task wr(input [3:0] m, input [31:0] d);
    begin
      @(posedge I_CLK);
      i_status_we <= 1'b1;
      i_status_fmask <= m;
      i_status_wdata <= d;
      tick;
    end
  endtask
  task enter(input [4:0] m, input f);
    begin
      @(posedge I_CLK);
      i_exc_enter <= 1'b1;
      i_exc_mode <= m;
      i_exc_mask_fiq <= f;
      tick;
    end
  endtask
  task gw(input [3:0] a, input [31:0] d);
    begin
      @(posedge I_CLK);
      i_gpr_we <= 1'b1;
      i_gpr_waddr <= a;
      i_gpr_wdata <= d;
      tick;
    end
  endtask
  task gr(input [3:0] a, input [31:0] d);
    begin
      @(posedge I_CLK);
      i_gpr_raddr <= a;
      tick;
      check("gpr", O_GPR_RDATA, d);
    end
  endtask
  task t_fields_flags;
    begin
      wr(4'hF, 32'hF9A55AD3);
      check("status", O_CURRENT_STATUS, 32'hF8A55AD3);
      wr(4'h8, 32'h00000000);
      check("status", O_CURRENT_STATUS, 32'h00A55AD3);
      @(posedge I_CLK);
      i_sat_set <= 1'b1;
      tick;
      check("status", O_CURRENT_STATUS, 32'h08A55AD3);
      @(posedge I_CLK);
      i_flag_we <= 1'b1;
      i_flag_nzcv <= 4'h5;
      tick;
      check("status", O_CURRENT_STATUS, 32'h58A55AD3);
      @(posedge I_CLK);
      i_cond <= 4'h1;
      tick;
      check("cond", O_COND_PASS, 1'b0);
    end
  endtask
  task t_state_entry;
    begin
      @(posedge I_CLK);
      i_state_we <= 1'b1;
      i_state_compact <= 1'b1;
      i_state_bytecode <= 1'b1;
      tick;
      check("pins", {O_BYTECODE_STATE_OUT, O_COMPACT_STATE_OUT, O_UNDEF_TRAP}, 3'h7);
      enter(5'h1B, 1'b0);
      check("saved", O_SAVED_STATUS, 32'h59A55AF3);
      check("status", O_CURRENT_STATUS, 32'h58A55ADB);
    end
  endtask
  task t_banking;
    begin
      gw(4'h8, 32'h000000A8);
      gw(4'hD, 32'h000000AD);
      enter(5'h11, 1'b1);
      gw(4'h8, 32'h000000F8);
      gw(4'hD, 32'h000000FD);
      gr(4'h8, 32'h000000F8);
      @(posedge I_CLK);
      i_exc_return <= 1'b1;
      tick;
      gr(4'h8, 32'h000000A8);
      gr(4'hD, 32'h000000AD);
    end
  endtask
  task t_compact;
    begin
      @(posedge I_CLK);
      i_state_we <= 1'b1;
      i_state_compact <= 1'b1;
      i_state_bytecode <= 1'b0;
      tick;
      check("status", O_CURRENT_STATUS, 32'h58A55AFB);
      gw(4'h8, 32'h00000055);
      check("access err", O_ACCESS_ERR, 1'b1);
      @(posedge I_CLK);
      i_high_access <= 1'b1;
      gr(4'h8, 32'h000000A8);
      check("access err", O_ACCESS_ERR, 1'b0);
      @(posedge I_CLK);
      i_high_access <= 1'b0;
      i_is_branch <= 1'b0;
      tick;
      check("cond", O_COND_PASS, 1'b1);
      @(posedge I_CLK);
      i_is_branch <= 1'b1;
      tick;
      check("cond", O_COND_PASS, 1'b0);
      @(posedge I_CLK);
      i_is_branch <= 1'b0;
      i_status_to_saved <= 1'b1;
      wr(4'hF, 32'h12345678);
      check("saved", O_SAVED_STATUS, 32'h12345678);
      check("status", O_CURRENT_STATUS, 32'h58A55AFB);
      i_status_to_saved <= 1'b0;
      @(posedge I_CLK);
      i_state_we <= 1'b1;
      i_state_compact <= 1'b0;
      tick;
      check("status", O_CURRENT_STATUS, 32'h58A55ADB);
    end
  endtask
  task t_masks_user;
    begin
      @(posedge I_CLK);
      i_irq_req <= 1'b1;
      i_fiq_req <= 1'b1;
      tick;
      check("takes", {O_IRQ_TAKE, O_FIQ_TAKE}, 2'h0);
      wr(4'h1, 32'h0000001B);
      check("takes", {O_IRQ_TAKE, O_FIQ_TAKE}, 2'h3);
      wr(4'h1, 32'h00000010);
      wr(4'h9, 32'h000000D3);
      check("status", O_CURRENT_STATUS, 32'h00A55A10);
      enter(5'h13, 1'b1);
      wr(4'h1, 32'h00000015);
      check("locked", O_LOCKED, 1'b1);
      @(posedge I_CLK);
      i_flag_we <= 1'b1;
      i_flag_nzcv <= 4'hF;
      tick;
      check("flags", O_CURRENT_STATUS[31:28], 4'h0);
    end
  endtask
  initial begin
    {i_flag_we, i_sat_set, i_status_we, i_status_to_saved, i_exc_enter, i_exc_mask_fiq} = 6'h00;
    {i_exc_return, i_state_we, i_state_compact, i_state_bytecode, i_high_access} = 5'h00;
    {i_is_branch, i_irq_req, i_fiq_req, i_gpr_we, i_flag_nzcv, i_status_fmask} = 12'h000;
    {i_cond, i_gpr_waddr, i_gpr_raddr, i_exc_mode} = 17'h00000;
    {i_status_wdata, i_gpr_wdata} = 64'h0;
    repeat (6) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    #1;
    check("status", O_CURRENT_STATUS, 32'h000000D3);
    t_fields_flags;
    t_state_entry;
    t_banking;
    t_compact;
    t_masks_user;
    report_and_stop;
  end
endmodule

// [status_regs_monitor.sv]
// Port-level assertions for the status register block.
`timescale 1ns/1ps
module status_regs_monitor (
  input wire        I_CLK,
  input wire        I_RST,
  input wire        i_status_we,
  input wire        i_status_to_saved,
  input wire        i_sat_set,
  input wire        i_exc_enter,
  input wire [4:0]  i_exc_mode,
  input wire        i_exc_return,
  input wire        i_state_we,
  input wire        i_irq_req,
  input wire [31:0] O_CURRENT_STATUS,
  input wire [31:0] O_SAVED_STATUS,
  input wire        O_COMPACT_STATE_OUT,
  input wire        O_BYTECODE_STATE_OUT,
  input wire        O_UNDEF_TRAP,
  input wire        O_IRQ_TAKE,
  input wire        O_LOCKED
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // Higher-priority operations in the same cycle would hide a plain update.
  wire quiet = !i_exc_enter && !i_exc_return && !i_state_we && !O_LOCKED;
  a_reset_value: assert property (
    $fell(I_RST) |-> O_CURRENT_STATUS == 32'h000000D3) else $error("bad reset status");
  a_pin_compact: assert property (
    O_COMPACT_STATE_OUT == O_CURRENT_STATUS[5]) else $error("compact pin mismatch");
  a_pin_bytecode: assert property (
    O_BYTECODE_STATE_OUT == O_CURRENT_STATUS[24]) else $error("bytecode pin mismatch");
  a_undef_trap: assert property (
    O_UNDEF_TRAP == (O_CURRENT_STATUS[24] && O_CURRENT_STATUS[5])) else $error("trap wrong");
  a_bytecode_kept: assert property (
    i_status_we && !i_status_to_saved && quiet |-> ##2 $stable(O_CURRENT_STATUS[24]))
    else $error("status write changed bytecode bit");
  a_sat_sticky: assert property (
    i_sat_set && quiet |-> ##2 O_CURRENT_STATUS[27]) else $error("saturation not set");
  a_entry_saves: assert property (
    i_exc_enter && !O_LOCKED |-> ##2 O_SAVED_STATUS == $past(O_CURRENT_STATUS)
    && O_CURRENT_STATUS[4:0] == $past(i_exc_mode, 2) && O_CURRENT_STATUS[7])
    else $error("entry did not save status");
  a_irq_masked: assert property (
    O_IRQ_TAKE |-> !O_CURRENT_STATUS[7] && $past(i_irq_req)) else $error("masked irq taken");
  a_user_ctrl: assert property (
    O_CURRENT_STATUS[4:0] == 5'h10 && !$past(i_exc_enter) |=>
    $stable({O_CURRENT_STATUS[7:6], O_CURRENT_STATUS[4:0]})) else $error("user changed control");
endmodule
bind status_regs_and_banking status_regs_monitor u_mon (.I_CLK(I_CLK), .I_RST(I_RST),
  .i_status_we(i_status_we), .i_status_to_saved(i_status_to_saved), .i_sat_set(i_sat_set),
  .i_exc_enter(i_exc_enter), .i_exc_mode(i_exc_mode), .i_exc_return(i_exc_return),
  .i_state_we(i_state_we), .i_irq_req(i_irq_req), .O_CURRENT_STATUS(O_CURRENT_STATUS),
  .O_SAVED_STATUS(O_SAVED_STATUS), .O_COMPACT_STATE_OUT(O_COMPACT_STATE_OUT),
  .O_BYTECODE_STATE_OUT(O_BYTECODE_STATE_OUT), .O_UNDEF_TRAP(O_UNDEF_TRAP),
  .O_IRQ_TAKE(O_IRQ_TAKE), .O_LOCKED(O_LOCKED));
